// >>> hdl/des_pkg.sv
// package for the drive enable state machine: control and status word
// layout, state encoding, register map and timing constants.
// assumes a 250 MHz system clock and an AXI4-Lite register master.
// Functional notes
// - after reset run self-test with bus inactive, then rest in inhibit.
// - operation is reached from inhibit only via three enabling steps.
// - disable-operation 0111 leaves operation, braking along the stop ramp.
// - coast stop xx0x switches the output stage off at once.
// - any error eventually leads to inhibit, after emergency braking if needed.
// - with hardware plus bus enable, armed waits for the enable input.
// - status bits 6,2,1,0 mask 0047; inhibit 0040, armed 0001.
// - powered reads 0003, operation 0007; master compares masked values.
// - commands from bits 3..0; shutdown x110 moves inhibit to armed.
// - switch-on x111 in armed enables power stage, enters powered.
// - enable-operation 1111 in powered enters operation.
// - x bits ignored; quick stop x01x leads to inhibit, via the stop ramp from operation.
// - power stage disabled stops switching and engages the brake.
// - power stage enabled releases the brake; the controller runs only in operation and while stopping.
// - status bit 9 mirrors control word bit 10.
package des_pkg;
    typedef enum {
        DES_SELFTEST, DES_INHIBIT, DES_ARMED, DES_POWERED, DES_OPERATION,
        DES_STOPPING
    } des_state_t;

    localparam logic [15:0] DES_STAT_MASK = 16'h0047;
    localparam logic [15:0] DES_STAT_INHIBIT = 16'h0040;
    localparam logic [15:0] DES_STAT_ARMED = 16'h0001;
    localparam logic [15:0] DES_STAT_POWERED = 16'h0003;
    localparam logic [15:0] DES_STAT_OPERATION = 16'h0007;
    localparam int DES_BIT_MASTER_CTRL = 10;
    localparam int DES_BIT_MASTER_STAT = 9;

    localparam logic [7:0] DES_ADDR_CTRL = 8'h00;
    localparam logic [7:0] DES_ADDR_STATUS = 8'h04;
    localparam logic [7:0] DES_ADDR_CONFIG = 8'h08;
    localparam logic [7:0] DES_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] DES_ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] DES_ADDR_ERROR = 8'h14;

    localparam int DES_IRQ_W = 4;
    localparam int DES_IRQ_STATE = 0;
    localparam int DES_IRQ_ERROR = 1;
    localparam int DES_IRQ_STOPPED = 2;
    localparam int DES_IRQ_IGNORED = 3;

    localparam logic [15:0] DES_CTRL_RESET = 16'h0000;
    localparam logic [1:0] DES_CONFIG_RESET = 2'h0;

    localparam int DES_CLK_MHZ = 250;
    localparam int DES_SELFTEST_US = 100;
    localparam int DES_SELFTEST_CYC = DES_SELFTEST_US * DES_CLK_MHZ;
    localparam int DES_RAMP_US = 1000;
    localparam int DES_RAMP_CYC = DES_RAMP_US * DES_CLK_MHZ;
    localparam int DES_CNT_W = 24;
endpackage

// >>> hdl/des_sync.sv
// two-flop synchroniser for asynchronous level inputs.
// assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ps
module des_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// >>> hdl/des_top.sv
// drive power-stage enable state machine with an AXI4-Lite register file.
// assumes the cyclic control word is written by software at offset 0 and
// that hardware inputs (controller enable, error) are asynchronous pins.
`timescale 1ns/1ps
module des_top #(
    parameter int SELFTEST_CYC = des_pkg::DES_SELFTEST_CYC,
    parameter int RAMP_CYC = des_pkg::DES_RAMP_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // drive pins
    input wire logic hwEnable,
    input wire logic driveError,
    input wire logic motorStandstill,
    output logic powerStageOn,
    output logic controllerOn,
    output logic brakeRelease,
    output logic fieldbusActive,
    output logic irq
);
    import des_pkg::*;

    des_state_t stateReg, stateNext;
    logic [DES_CNT_W-1:0] cntReg;
    logic [15:0] ctrlReg, statusWord;
    logic ctrlNewReg, errLatchReg;
    logic [1:0] configReg;
    logic [DES_IRQ_W-1:0] irqStatReg, irqMaskReg, irqEvent;
    logic hwEnS, errS, standS;
    logic [3:0] cmd, wStrbReg;
    logic cmdShutdown, cmdSwitchOn, cmdEnableOp, cmdDisableOp;
    logic cmdCoast, cmdQuick, cmdValid, ignored;
    logic wrAddrHeld, wrDataHeld, doWrite;
    logic [7:0] awAddrReg;
    logic [31:0] wDataReg;

    des_sync #(.WIDTH(3)) des_sync_inst (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din({motorStandstill, driveError, hwEnable}),
        .dout({standS, errS, hwEnS})
    );

    // command decode, x bits ignored
    assign cmd = ctrlReg[3:0];
    assign cmdCoast = !cmd[1];
    assign cmdQuick = cmd[1] && !cmd[2];
    assign cmdShutdown = cmd[2:0] == 3'h6;
    assign cmdSwitchOn = cmd[2:0] == 3'h7;
    assign cmdEnableOp = cmd == 4'hF;
    assign cmdDisableOp = cmd == 4'h7;
    // bit 10 must be set for the master to be in control
    assign cmdValid = ctrlNewReg && ctrlReg[DES_BIT_MASTER_CTRL];

    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            DES_SELFTEST:
                if (cntReg == DES_CNT_W'(SELFTEST_CYC - 1)) begin
                    stateNext = DES_INHIBIT;
                end
            DES_INHIBIT:
                if (cmdValid && cmdShutdown) begin
                    stateNext = DES_ARMED;
                end
            DES_ARMED:
                if (cmdValid && (cmdCoast || cmdQuick)) begin
                    stateNext = DES_INHIBIT;
                end else if (cmdValid && cmdSwitchOn
                        && (configReg[0] == 1'b0 || hwEnS)) begin
                    stateNext = DES_POWERED;
                end
            DES_POWERED:
                if (cmdValid && (cmdCoast || cmdQuick)) begin
                    stateNext = DES_INHIBIT;
                end else if (cmdValid && cmdShutdown) begin
                    stateNext = DES_ARMED;
                end else if (cmdValid && cmdEnableOp) begin
                    stateNext = DES_OPERATION;
                end
            DES_OPERATION:
                if (cmdValid && cmdCoast) begin
                    stateNext = DES_INHIBIT;
                end else if (cmdValid && cmdQuick) begin
                    stateNext = DES_STOPPING;
                end else if (cmdValid && (cmdDisableOp || cmdShutdown)) begin
                    stateNext = DES_STOPPING;
                end
            DES_STOPPING:
                if (cmdValid && cmdCoast) begin
                    stateNext = DES_INHIBIT;
                end else if (standS
                        || cntReg == DES_CNT_W'(RAMP_CYC - 1)) begin
                    stateNext = ctrlReg[1] && ctrlReg[2] && !errLatchReg
                        ? DES_POWERED : DES_INHIBIT;
                end
            default: stateNext = DES_INHIBIT;
        endcase
        // error overrides; braking first when the motor may be running
        if (errLatchReg && stateReg != DES_SELFTEST) begin
            if (stateReg == DES_OPERATION) begin
                stateNext = DES_STOPPING;
            end else if (stateReg != DES_STOPPING) begin
                stateNext = DES_INHIBIT;
            end
        end
    end

    // one step per new control word since ctrlNewReg is set for one cycle only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= DES_SELFTEST;
        end else begin
            stateReg <= stateNext;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cntReg <= '0;
        end else if (stateNext != stateReg) begin
            cntReg <= '0;
        end else if (stateReg == DES_SELFTEST || stateReg == DES_STOPPING) begin
            cntReg <= cntReg + DES_CNT_W'(1);
        end
    end

    // error is sticky until the machine has reached inhibit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            errLatchReg <= 1'b0;
        end else if (errS) begin
            errLatchReg <= 1'b1;
        end else if (stateReg == DES_INHIBIT) begin
            errLatchReg <= 1'b0;
        end
    end

    // power stage outputs; controller stays on while ramping down
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            powerStageOn <= 1'b0;
            controllerOn <= 1'b0;
            brakeRelease <= 1'b0;
            fieldbusActive <= 1'b0;
        end else begin
            powerStageOn <= stateNext == DES_POWERED
                || stateNext == DES_OPERATION || stateNext == DES_STOPPING;
            controllerOn <= stateNext == DES_OPERATION
                || stateNext == DES_STOPPING;
            // brake follows the power stage
            brakeRelease <= stateNext == DES_POWERED
                || stateNext == DES_OPERATION || stateNext == DES_STOPPING;
            fieldbusActive <= stateNext != DES_SELFTEST;
        end
    end

    always_comb begin
        unique case (stateReg)
            DES_SELFTEST: statusWord = 16'h0000;
            DES_INHIBIT: statusWord = DES_STAT_INHIBIT;
            DES_ARMED: statusWord = DES_STAT_ARMED;
            DES_POWERED: statusWord = DES_STAT_POWERED;
            DES_OPERATION: statusWord = DES_STAT_OPERATION;
            DES_STOPPING: statusWord = DES_STAT_OPERATION;
            default: statusWord = 16'h0000;
        endcase
        statusWord[DES_BIT_MASTER_STAT] =
            ctrlReg[DES_BIT_MASTER_CTRL];
    end

    // events for the interrupt logic
    assign ignored = cmdValid && stateNext == stateReg
        && stateReg != DES_SELFTEST;
    always_comb begin
        irqEvent[DES_IRQ_STATE] = stateNext != stateReg;
        irqEvent[DES_IRQ_ERROR] = errS && !errLatchReg;
        irqEvent[DES_IRQ_STOPPED] = stateReg == DES_STOPPING
            && stateNext != DES_STOPPING;
        irqEvent[DES_IRQ_IGNORED] = ignored || (ctrlNewReg
            && !ctrlReg[DES_BIT_MASTER_CTRL]);
    end

    // axi write side: address and data accepted in either order
    assign doWrite = wrAddrHeld && wrDataHeld && !s_axi_bvalid;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrAddrHeld <= 1'b0;
            awAddrReg <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !wrAddrHeld && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                wrAddrHeld <= 1'b1;
                awAddrReg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (doWrite) begin
                wrAddrHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrDataHeld <= 1'b0;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !wrDataHeld && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                wrDataHeld <= 1'b1;
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (doWrite) begin
                wrDataHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddrReg[7:2] > DES_ADDR_ERROR[7:2])
                ? 2'h2 : 2'h0;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control word: each write after self-test is a new cyclic word, seen for one cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrlReg <= DES_CTRL_RESET;
            ctrlNewReg <= 1'b0;
        end else begin
            ctrlNewReg <= 1'b0;
            if (doWrite && awAddrReg == DES_ADDR_CTRL
                    && stateReg != DES_SELFTEST) begin
                if (wStrbReg[0]) begin
                    ctrlReg[7:0] <= wDataReg[7:0];
                end
                if (wStrbReg[1]) begin
                    ctrlReg[15:8] <= wDataReg[15:8];
                end
                ctrlNewReg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            configReg <= DES_CONFIG_RESET;
            irqMaskReg <= '0;
        end else if (doWrite && wStrbReg[0]) begin
            if (awAddrReg == DES_ADDR_CONFIG) begin
                configReg <= wDataReg[1:0];
            end
            if (awAddrReg == DES_ADDR_IRQ_MASK) begin
                irqMaskReg <= wDataReg[DES_IRQ_W-1:0];
            end
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqStatReg <= '0;
        end else if (doWrite && wStrbReg[0]
                && awAddrReg == DES_ADDR_IRQ_STAT) begin
            irqStatReg <= (irqStatReg & ~wDataReg[DES_IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStatReg <= irqStatReg | irqEvent;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatReg & irqMaskReg);
        end
    end

    // axi read side, one beat at a time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                s_axi_rdata <= 32'h0000_0000;
                unique case (s_axi_araddr)
                    DES_ADDR_CTRL: s_axi_rdata[15:0] <= ctrlReg;
                    DES_ADDR_STATUS: s_axi_rdata[15:0] <= statusWord;
                    DES_ADDR_CONFIG: s_axi_rdata[1:0] <= configReg;
                    DES_ADDR_IRQ_STAT:
                        s_axi_rdata[DES_IRQ_W-1:0] <= irqStatReg;
                    DES_ADDR_IRQ_MASK:
                        s_axi_rdata[DES_IRQ_W-1:0] <= irqMaskReg;
                    DES_ADDR_ERROR: s_axi_rdata[0] <= errLatchReg;
                    default: s_axi_rresp <= 2'h2;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> test/des_motor_model.sv
// motor plant seen by des_top: reports standstill after a short spin-down.
// assumes slowStop is driven by the bench to keep the shaft turning.
`timescale 1ns/1ps
module des_motor_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // drive side
    input wire logic powerStageOn,
    input wire logic controllerOn,
    input wire logic slowStop,
    output logic motorStandstill
);
    logic [3:0] spinCnt_reg;
    logic ctrlSeen_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            spinCnt_reg <= 4'h0;
            ctrlSeen_reg <= 1'b0;
        end else begin
            ctrlSeen_reg <= controllerOn;
            if (controllerOn && !ctrlSeen_reg) begin
                spinCnt_reg <= 4'hF;
            // slow shaft forces the drive onto its ramp timeout
            end else if (spinCnt_reg != 4'h0 && (!slowStop || !powerStageOn))
            begin
                spinCnt_reg <= spinCnt_reg - 4'h1;
            end
        end
    end
    assign motorStandstill = (spinCnt_reg == 4'h0);
endmodule

// >>> test/des_top_assertions.sv
// checker for des_top drive pins.
// assumes only top ports are visible; one clock domain.
`timescale 1ns/1ps
module des_top_assertions #(
    parameter int SELFTEST_CYC = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // drive pins
    input wire logic driveError,
    input wire logic powerStageOn,
    input wire logic controllerOn,
    input wire logic brakeRelease,
    input wire logic fieldbusActive,
    input wire logic irq
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    logic [15:0] idleCnt_reg;
    // saturates so a stuck flag cannot wrap into the window
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            idleCnt_reg <= 16'h0000;
        end else if (!fieldbusActive && idleCnt_reg != 16'hFFFF) begin
            idleCnt_reg <= idleCnt_reg + 16'h0001;
        end
    end
    brake_tracks_a:
    assert property (brakeRelease == powerStageOn)
        else $error("brake release differs from power stage");
    ctrl_needs_stage_a:
    assert property (controllerOn |-> powerStageOn)
        else $error("controller on without power stage");
    stage_first_a:
    assert property ($rose(powerStageOn) |-> !controllerOn)
        else $error("power stage and controller rose together");
    op_via_powered_a:
    assert property ($rose(controllerOn) |-> $past(powerStageOn))
        else $error("operation entered without powered state");
    stage_drop_a:
    assert property ($fell(powerStageOn) |-> !controllerOn)
        else $error("power stage dropped under controller");
    bus_stays_a:
    assert property (fieldbusActive |=> fieldbusActive)
        else $error("fieldbus dropped after self-test");
    selftest_idle_a:
    assert property (!fieldbusActive |-> !powerStageOn && !controllerOn)
        else $error("stage active during self-test");
    selftest_len_a:
    assert property ($rose(fieldbusActive) |->
        idleCnt_reg >= 16'(SELFTEST_CYC - 1) &&
        idleCnt_reg <= 16'(SELFTEST_CYC + 4))
        else $error("self-test length wrong");
    error_inhibit_a:
    assert property ($rose(driveError) |-> ##[1:60] !powerStageOn)
        else $error("error did not reach inhibit");
    cover property (controllerOn);
    cover property ($fell(controllerOn) && powerStageOn);
    cover property (irq);
endmodule
bind des_top des_top_assertions #(.SELFTEST_CYC(SELFTEST_CYC)) chk_inst (
    .clk_sys, .arst_n, .driveError, .powerStageOn, .controllerOn,
    .brakeRelease, .fieldbusActive, .irq
);

// >>> test/tb_drive_enable_state_machine.sv
// bench for des_top: axi4-lite register tasks and command sequences.
// assumes the motor model drives motorStandstill; short counts used.
`timescale 1ns/1ps
module tb_drive_enable_state_machine;
    import des_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n, hwEnable, driveError, motorStandstill, slowStop;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, powerStageOn, controllerOn;
    logic brakeRelease, fieldbusActive, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    int n_mismatch = 0;
    int n_tests = 0;

    always #2 clk_sys = ~clk_sys;

    des_top #(.SELFTEST_CYC(16), .RAMP_CYC(32)) des_top_inst (
        .clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .hwEnable, .driveError,
        .motorStandstill, .powerStageOn, .controllerOn, .brakeRelease,
        .fieldbusActive, .irq
    );
    des_motor_model des_motor_model_inst (
        .clk_sys, .arst_n, .powerStageOn, .controllerOn, .slowStop,
        .motorStandstill
    );

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // no cycle limit here: only the watchdog ends a wait
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axiRead(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    // the master waits for the masked status before moving on
    task automatic pollSt(input logic [15:0] exp, input string what);
        int n;
        n = 0;
        repeat (4) @(posedge clk_sys);
        do begin
            axiRead(DES_ADDR_STATUS);
            n++;
        end while ((rd[15:0] & DES_STAT_MASK) !== exp && n < 40);
        check(what, {16'h0000, rd[15:0] & DES_STAT_MASK}, {16'h0000, exp});
    endtask

    task automatic cmd(input logic [15:0] cw, input logic [15:0] exp,
            input string what);
        axiWrite(DES_ADDR_CTRL, {16'h0000, cw});
        pollSt(exp, what);
    endtask

    task automatic enableOp();
        cmd(16'h0406, DES_STAT_ARMED, "armed");
        cmd(16'h0407, DES_STAT_POWERED, "powered");
        check("brake", brakeRelease, 1'b1);
        cmd(16'h040F, DES_STAT_OPERATION, "operation");
        check("ctrl", controllerOn, 1'b1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #80000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        {hwEnable, driveError, slowStop} = 3'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr} = 16'h0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // a command during self-test must be dropped
        axiWrite(DES_ADDR_CTRL, 32'h0000_0406);
        check("selftest bresp", br, 2'h0);
        axiRead(DES_ADDR_STATUS);
        check("selftest status", rd & 32'h0047, 32'h0);
        pollSt(DES_STAT_INHIBIT, "inhibit");
        $display("test selftest done");
        enableOp();
        check("mirror", rd[DES_BIT_MASTER_STAT], 1'b1);
        cmd(16'h0407, DES_STAT_POWERED, "disable op");
        check("ctrl off", controllerOn, 1'b0);
        cmd(16'h040F, DES_STAT_OPERATION, "reenable");
        slowStop <= 1'b1;
        cmd(16'h0402, DES_STAT_INHIBIT, "quick stop op");
        check("stage off", powerStageOn, 1'b0);
        slowStop <= 1'b0;
        $display("test stops done");
        cmd(16'h040E, DES_STAT_ARMED, "shutdown x bit");
        cmd(16'h040A, DES_STAT_INHIBIT, "quick stop armed");
        cmd(16'h0006, DES_STAT_INHIBIT, "no master ctrl");
        check("mirror off", rd[DES_BIT_MASTER_STAT], 1'b0);
        axiRead(DES_ADDR_IRQ_STAT);
        check("ignored flag", rd[DES_IRQ_IGNORED], 1'b1);
        check("irq masked", irq, 1'b0);
        axiWrite(DES_ADDR_IRQ_MASK, 32'h0000_0008);
        @(posedge clk_sys);
        check("irq on", irq, 1'b1);
        axiWrite(DES_ADDR_IRQ_STAT, 32'h0000_0008);
        @(posedge clk_sys);
        check("irq cleared", irq, 1'b0);
        $display("test ignore done");
        axiWrite(DES_ADDR_CONFIG, 32'h0000_0001);
        cmd(16'h0406, DES_STAT_ARMED, "armed hw");
        cmd(16'h0407, DES_STAT_ARMED, "hw refuse");
        hwEnable <= 1'b1;
        cmd(16'h0407, DES_STAT_POWERED, "hw allow");
        cmd(16'h0405, DES_STAT_INHIBIT, "coast");
        check("coast brake", brakeRelease, 1'b0);
        axiWrite(DES_ADDR_CONFIG, 32'h0000_0000);
        $display("test hw enable done");
        enableOp();
        slowStop <= 1'b1;
        driveError <= 1'b1;
        pollSt(DES_STAT_INHIBIT, "error");
        check("error stage", powerStageOn, 1'b0);
        axiRead(DES_ADDR_ERROR);
        check("error latch", rd, 32'h1);
        {driveError, slowStop} <= 2'h0;
        axiRead(8'h20);
        check("unmapped resp", rr, 2'h2);
        check("unmapped data", rd, 32'h0);
        axiWrite(8'h20, 32'h0000_0000);
        check("unmapped bresp", br, 2'h2);
        $display("test error done");
        // shaft held turning so the shutdown stop runs into the ramp timeout; the next stop is ended by coast
        slowStop <= 1'b1;
        enableOp();
        cmd(16'h0406, DES_STAT_POWERED, "shutdown op");
        cmd(16'h040F, DES_STAT_OPERATION, "op again");
        axiWrite(DES_ADDR_CTRL, 32'h0000_0407);
        axiWrite(DES_ADDR_CTRL, 32'h0000_0405);
        @(posedge clk_sys);
        check("coast in ramp", powerStageOn, 1'b0);
        pollSt(DES_STAT_INHIBIT, "coast op");
        axiRead(DES_ADDR_IRQ_STAT);
        check("irq events", rd, 32'h0000_000F);
        slowStop <= 1'b0;
        $display("test ramp done");
        complete_run();
    end
endmodule
